/* pvf_divider.sv */
`timescale 1ns/1ps
module pvf_divider #(
  parameter int NW = 32,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request
  input wire logic start,
  input wire logic [NW-1:0] numer,
  input wire logic [DW-1:0] denom,
  // answer
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  localparam int CW = $clog2(NW + 1);

  logic [DW:0] rem_q;
  logic [DW-1:0] den_q;
  logic [CW-1:0] cnt_q;
  logic [DW:0] trial;

  // shift next numerator bit into the partial remainder
  assign trial = {rem_q[DW-1:0], quot[NW-1]};

  // restoring divide, one quotient bit per cycle; slow but tiny
  always_ff @(posedge clk) begin
    if (srst) begin
      rem_q <= '0;
      den_q <= '0;
      cnt_q <= '0;
      quot <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem_q <= '0;
        den_q <= denom;
        quot <= numer;
        cnt_q <= CW'(NW);
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, den_q}) begin
          rem_q <= trial - {1'b0, den_q};
          quot <= {quot[NW-2:0], 1'b1};
        end else begin
          rem_q <= trial;
          quot <= {quot[NW-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == CW'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule // pvf_divider

/* pvf_front_model.sv */
`timescale 1ns/1ps
module pvf_front_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // values commanded by the bench
  input wire logic [15:0] level,
  input wire logic [15:0] ab_diff,
  input wire logic [15:0] meas,
  input wire logic meas_req,
  // toward the filter
  output logic [15:0] pv_in,
  output logic pv_in_valid,
  output logic [15:0] res_ab_diff,
  output logic [15:0] res_meas,
  output logic res_meas_valid
);
  logic [5:0] gap_q;
  // sample every 50 clocks, faster than the filter tick
  always_ff @(posedge clk) begin
    gap_q <= (srst || gap_q == 6'h31) ? 6'h00 : gap_q + 6'h01;
  end
  // data is inverted between strobes so a stray latch shows
  always_ff @(posedge clk) begin
    pv_in_valid <= !srst && gap_q == 6'h31;
    pv_in <= (gap_q == 6'h31) ? level : ~level;
  end
  // resistance reading on request only
  always_ff @(posedge clk) begin
    res_meas_valid <= !srst && meas_req;
    res_meas <= meas_req ? meas : ~meas;
  end
  // line difference is a live measurement, always present
  assign res_ab_diff = ab_diff;
endmodule // pvf_front_model

/* pvf_pkg.sv */
// Operation
// - filter steps output by difference over T/Ts+1
// - lag time 0 bypass, 0.1 to 120.0 s
// - max hold replaces only on larger sample
// - min hold replaces only on smaller sample
// - any hold mode drives the blink output
// - limits sit at -10 and +110 percent
// - delivered value saturates between both limits
// - alarms compare the raw sample with limits
// - special code 0..15, value 5 enables calibration
// - correction +-20 ohm, shows -19.99, capture only
// - no calibration for non resistance thermometer inputs
// - calibration only for types 41-52, 63-68
// - first confirm captures and shows A-B difference
// - second confirm stores difference as correction
// - difference of 20 ohm or more stores zero
// - correction survives change of thermometer type
// - compensated value is input times ratio plus bias
package pvf_pkg;

  // widths
  localparam int PV_W = 16;
  localparam int EXT_W = 20;
  localparam int FRAC_W = 8;
  localparam int ACC_W = EXT_W + FRAC_W;

  // register byte offsets
  localparam logic [7:0] OFS_LAG = 8'h00;
  localparam logic [7:0] OFS_RATIO = 8'h04;
  localparam logic [7:0] OFS_BIAS = 8'h08;
  localparam logic [7:0] OFS_CODE = 8'h0C;
  localparam logic [7:0] OFS_TYPE = 8'h10;
  localparam logic [7:0] OFS_RANGE_LO = 8'h14;
  localparam logic [7:0] OFS_RANGE_HI = 8'h18;
  localparam logic [7:0] OFS_CORR = 8'h1C;
  localparam logic [7:0] OFS_CAL_CMD = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_PV = 8'h28;
  localparam logic [7:0] OFS_DIFF = 8'h2C;

  // reset values
  localparam logic [11:0] LAG_RST = 12'h000;
  localparam logic [13:0] RATIO_RST = 14'h03E8;
  localparam logic [15:0] BIAS_RST = 16'h0000;
  localparam logic [3:0] CODE_RST = 4'h0;
  localparam logic [7:0] TYPE_RST = 8'h29;
  localparam logic [15:0] RANGE_LO_RST = 16'h0000;
  localparam logic [15:0] RANGE_HI_RST = 16'h03E8;
  localparam logic [15:0] CORR_RST = 16'h0000;

  // setting ranges
  localparam logic [11:0] LAG_MAX = 12'h04B0;
  localparam logic [13:0] RATIO_MIN = 14'h0001;
  localparam logic [13:0] RATIO_MAX = 14'h270F;
  localparam logic signed [30:0] RATIO_SCALE = 31'sh0000_03E8;
  localparam logic [3:0] CAL_CODE = 4'h5;
  localparam logic [7:0] BAR_A_LO = 8'h29;
  localparam logic [7:0] BAR_A_HI = 8'h34;
  localparam logic [7:0] BAR_B_LO = 8'h3F;
  localparam logic [7:0] BAR_B_HI = 8'h44;
  localparam logic [7:0] RTD_LO = 8'h29;
  localparam logic [7:0] RTD_HI = 8'h44;
  localparam logic signed [16:0] LIMIT_DIV = 17'sh0_000A;
  localparam logic [15:0] CORR_LIMIT = 16'h07D0;
  localparam logic signed [15:0] CORR_SHOW_MIN = 16'shF831;

  // status bit positions
  localparam int ST_ALM_HI = 0;
  localparam int ST_ALM_LO = 1;
  localparam int ST_BLINK = 2;
  localparam int ST_CAL_AVAIL = 3;
  localparam int ST_CAL_SHOWN = 4;
  localparam int ST_CAL_REJECT = 5;

  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SAMPLE_TIME_MS = 500;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_TIME_MS;
  localparam logic [15:0] TS_TENTHS = 16'h0005;

  typedef enum logic [1:0] {
    FLT_IDLE = 2'b00,
    FLT_DIV = 2'b01,
    FLT_DONE = 2'b10
  } pvf_flt_t;

  typedef enum logic {
    CAL_IDLE = 1'b0,
    CAL_SHOWN = 1'b1
  } pvf_cal_t;

endpackage

/* pvf_props.sv */
`timescale 1ns/1ps
module pvf_props (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // apb handshake
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // hold pins
  input wire logic DI_HOLD,
  input wire logic DI_MAX_HOLD,
  input wire logic DI_MIN_HOLD,
  // outputs under watch
  input wire logic [pvf_pkg::EXT_W-1:0] PV_OUT,
  input wire logic PV_OUT_VALID,
  input wire logic PV_BLINK,
  input wire logic RES_MEAS_VALID,
  input wire logic RES_CORR_VALID
);
  import pvf_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // apb answers in the single access cycle
  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_unmapped: assert property (PSEL && !PENABLE && PADDR > OFS_DIFF |=> PSLVERR && PREADY)
    else $error("unmapped access without error");
  a_mapped_no_err: assert property (PSEL && !PENABLE && PADDR <= OFS_DIFF && PADDR[1:0] == 2'h0 |=> !PSLVERR)
    else $error("error on mapped access");
  // windows leave room for the two-stage pin synchroniser
  a_blink_on_hold: assert property ((DI_HOLD || DI_MAX_HOLD || DI_MIN_HOLD)[*5] |-> PV_BLINK)
    else $error("blink missing in hold");
  a_blink_idle: assert property ((!DI_HOLD && !DI_MAX_HOLD && !DI_MIN_HOLD)[*5] |-> !PV_BLINK)
    else $error("blink without hold");
  a_hold_freezes: assert property (DI_HOLD[*8] |=> $stable(PV_OUT))
    else $error("value moved in hold");
  a_max_no_drop: assert property ((DI_MAX_HOLD && !DI_HOLD)[*8] |-> $signed(PV_OUT) >= $signed($past(PV_OUT)))
    else $error("value fell in max hold");
  a_min_no_rise: assert property ((DI_MIN_HOLD && !DI_MAX_HOLD && !DI_HOLD)[*8]
    |-> $signed(PV_OUT) <= $signed($past(PV_OUT)))
    else $error("value rose in min hold");
  a_valid_pulse: assert property (PV_OUT_VALID |=> !PV_OUT_VALID)
    else $error("output strobe too long");
  a_corr_follows: assert property (RES_MEAS_VALID |=> RES_CORR_VALID)
    else $error("corrected value missing");
  a_corr_no_spur: assert property (!RES_MEAS_VALID |=> !RES_CORR_VALID)
    else $error("corrected value without request");
endmodule // pvf_props

bind pvf_top pvf_props i_props (
  .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DI_HOLD(DI_HOLD), .DI_MAX_HOLD(DI_MAX_HOLD), .DI_MIN_HOLD(DI_MIN_HOLD),
  .PV_OUT(PV_OUT), .PV_OUT_VALID(PV_OUT_VALID), .PV_BLINK(PV_BLINK),
  .RES_MEAS_VALID(RES_MEAS_VALID), .RES_CORR_VALID(RES_CORR_VALID)
);

/* pvf_top.sv */
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pvf_top #(
  parameter int SAMPLE_CYC = pvf_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // sample stream from the front end
  input wire logic [pvf_pkg::PV_W-1:0] PV_IN,
  input wire logic PV_IN_VALID,
  // digital input hold functions, asynchronous pins
  input wire logic DI_HOLD,
  input wire logic DI_MAX_HOLD,
  input wire logic DI_MIN_HOLD,
  // resistance measurement, 0.01 ohm units
  input wire logic [15:0] RES_AB_DIFF,
  input wire logic [15:0] RES_MEAS,
  input wire logic RES_MEAS_VALID,
  // conditioned value to the control algorithm
  output logic [pvf_pkg::EXT_W-1:0] PV_OUT,
  output logic PV_OUT_VALID,
  output logic UPPER_LIMIT_ALARM,
  output logic LOWER_LIMIT_ALARM,
  output logic PV_BLINK,
  output logic [15:0] RES_CORR,
  output logic RES_CORR_VALID
);
  import pvf_pkg::*;

  localparam int TW = $clog2(SAMPLE_CYC + 1);

  logic [2:0] di_meta_q;
  logic [2:0] di_sync_q;
  logic [11:0] lag_time_setting_q;
  logic [13:0] ratio_q;
  logic [15:0] bias_q;
  logic [3:0] special_function_code_q;
  logic [7:0] type_q;
  logic [15:0] range_lo_q;
  logic [15:0] range_hi_q;
  logic signed [15:0] lead_resistance_correction_q;
  logic signed [15:0] diff_q;
  logic cal_reject_q;
  pvf_cal_t cal_q;
  logic [PV_W-1:0] raw_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  pvf_flt_t flt_q;
  logic signed [ACC_W-1:0] acc_q;
  logic neg_q;
  logic upd_q;
  logic [2:0] hold_prev_q;
  logic signed [EXT_W-1:0] pv_q;
  logic [31:0] rd_d;
  logic mapped;
  logic acc_wr;
  logic cal_press;
  logic bar_type;
  logic rtd_type;
  logic cal_avail;
  logic signed [30:0] prod;
  logic signed [30:0] scaled;
  logic signed [EXT_W-1:0] comp;
  logic signed [16:0] span;
  logic signed [16:0] tenth;
  logic signed [EXT_W-1:0] lim_lo;
  logic signed [EXT_W-1:0] lim_hi;
  logic signed [EXT_W-1:0] raw_ext;
  logic signed [ACC_W:0] delta;
  logic [31:0] numer;
  logic [ACC_W:0] delta_mag;
  logic div_done;
  logic [31:0] quot;
  logic signed [EXT_W-1:0] filt;
  logic signed [EXT_W-1:0] clamped;
  logic signed [15:0] corr_show;
  logic [15:0] diff_mag;

  // hold pins come from outside the clock domain
  always_ff @(posedge CLK) begin
    if (SRST) begin
      di_meta_q <= 3'h0;
      di_sync_q <= 3'h0;
    end else begin
      di_meta_q <= {DI_MIN_HOLD, DI_MAX_HOLD, DI_HOLD};
      di_sync_q <= di_meta_q;
    end
  end

  // apb decode; write takes effect at the access edge only
  assign acc_wr = PSEL && PENABLE && PREADY && PWRITE;
  assign cal_press = acc_wr && (PADDR == OFS_CAL_CMD) && PWDATA[0];
  always_comb begin
    case (PADDR)
      OFS_LAG, OFS_RATIO, OFS_BIAS, OFS_CODE, OFS_TYPE, OFS_RANGE_LO, OFS_RANGE_HI,
      OFS_CORR, OFS_CAL_CMD, OFS_STATUS, OFS_PV, OFS_DIFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // settings; out of range lag or ratio values are ignored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lag_time_setting_q <= LAG_RST;
      ratio_q <= RATIO_RST;
      bias_q <= BIAS_RST;
      special_function_code_q <= CODE_RST;
      type_q <= TYPE_RST;
      range_lo_q <= RANGE_LO_RST;
      range_hi_q <= RANGE_HI_RST;
    end else if (acc_wr) begin
      case (PADDR)
        OFS_LAG: if (PWDATA[31:12] == 20'h0_0000 && PWDATA[11:0] <= LAG_MAX) lag_time_setting_q <= PWDATA[11:0];
        OFS_RATIO: if (PWDATA[31:14] == 18'h0_0000 && PWDATA[13:0] >= RATIO_MIN && PWDATA[13:0] <= RATIO_MAX)
          ratio_q <= PWDATA[13:0];
        OFS_BIAS: bias_q <= PWDATA[15:0];
        OFS_CODE: special_function_code_q <= PWDATA[3:0];
        OFS_TYPE: type_q <= PWDATA[7:0];
        OFS_RANGE_LO: range_lo_q <= PWDATA[15:0];
        OFS_RANGE_HI: range_hi_q <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  // calibration is offered only for barrier capable thermometer types
  assign bar_type = (type_q >= BAR_A_LO && type_q <= BAR_A_HI) || (type_q >= BAR_B_LO && type_q <= BAR_B_HI);
  assign rtd_type = (type_q >= RTD_LO) && (type_q <= RTD_HI);
  assign cal_avail = (special_function_code_q == CAL_CODE) && bar_type && rtd_type;
  assign diff_mag = diff_q[15] ? 16'(-diff_q) : diff_q;

  // two confirm presses: capture, then store; no direct entry path
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cal_q <= CAL_IDLE;
      diff_q <= 16'sh0000;
      cal_reject_q <= 1'b0;
      lead_resistance_correction_q <= CORR_RST;
    end else begin
      case (cal_q)
        CAL_IDLE: begin
          if (cal_press && cal_avail) begin
            diff_q <= RES_AB_DIFF;
            cal_q <= CAL_SHOWN;
          end
        end
        CAL_SHOWN: begin
          if (!cal_avail) begin
            cal_q <= CAL_IDLE;
          end else if (cal_press) begin
            cal_q <= CAL_IDLE;
            if (diff_mag >= CORR_LIMIT) begin
              lead_resistance_correction_q <= CORR_RST;
              cal_reject_q <= 1'b1;
            end else begin
              lead_resistance_correction_q <= diff_q;
              cal_reject_q <= 1'b0;
            end
          end
        end
        default: cal_q <= CAL_IDLE;
      endcase
    end
  end

  // correction applies to resistance thermometer types only, kept across changes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RES_CORR <= 16'h0000;
      RES_CORR_VALID <= 1'b0;
    end else begin
      RES_CORR_VALID <= RES_MEAS_VALID;
      if (RES_MEAS_VALID) begin
        RES_CORR <= rtd_type ? RES_MEAS - lead_resistance_correction_q : RES_MEAS;
      end
    end
  end

  // latest sample; front end is on this clock so no synchroniser
  always_ff @(posedge CLK) begin
    if (SRST) begin
      raw_q <= '0;
    end else if (PV_IN_VALID) begin
      raw_q <= PV_IN;
    end
  end

  // ratio and bias; ratio is in thousandths
  assign prod = 31'($signed(raw_q) * $signed({1'b0, ratio_q}));
  assign scaled = prod / RATIO_SCALE;
  assign comp = EXT_W'(scaled) + EXT_W'($signed(bias_q));

  // limits at -10 and +110 percent of the range span
  assign span = $signed({range_hi_q[15], range_hi_q}) - $signed({range_lo_q[15], range_lo_q});
  assign tenth = span / LIMIT_DIV;
  assign lim_lo = EXT_W'($signed(range_lo_q)) - EXT_W'(tenth);
  assign lim_hi = EXT_W'($signed(range_hi_q)) + EXT_W'(tenth);
  assign raw_ext = EXT_W'($signed(raw_q));

  // alarms use the sample before ratio, bias and filter
  always_ff @(posedge CLK) begin
    if (SRST) begin
      UPPER_LIMIT_ALARM <= 1'b0;
      LOWER_LIMIT_ALARM <= 1'b0;
    end else begin
      UPPER_LIMIT_ALARM <= raw_ext > lim_hi;
      LOWER_LIMIT_ALARM <= raw_ext < lim_lo;
    end
  end

  // sampling tick, one pulse per sampling period
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(SAMPLE_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // step = (in - out) * Ts / (T + Ts), all in tenths of a second
  assign delta = ($signed({comp, {FRAC_W{1'b0}}}) >>> 0) - (ACC_W + 1)'(acc_q);
  assign delta_mag = delta[ACC_W] ? (ACC_W + 1)'(-delta) : delta;
  assign numer = 32'(delta_mag) * 32'(TS_TENTHS);

  pvf_divider #(
    .NW(32),
    .DW(16)
  ) u_div (
    .clk(CLK),
    .srst(SRST),
    .start(tick_q && (flt_q == FLT_IDLE) && (lag_time_setting_q != LAG_RST)),
    .numer(numer),
    .denom(16'({4'h0, lag_time_setting_q}) + TS_TENTHS),
    .busy(),
    .done(div_done),
    .quot(quot)
  );

  // filter state; fraction bits keep slow lags from stalling
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flt_q <= FLT_IDLE;
      acc_q <= '0;
      neg_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= 1'b0;
      case (flt_q)
        FLT_IDLE: begin
          if (tick_q) begin
            if (lag_time_setting_q == LAG_RST) begin
              acc_q <= {comp, {FRAC_W{1'b0}}};
              upd_q <= 1'b1;
            end else begin
              neg_q <= delta[ACC_W];
              flt_q <= FLT_DIV;
            end
          end
        end
        FLT_DIV: begin
          if (div_done) begin
            acc_q <= neg_q ? acc_q - ACC_W'(quot) : acc_q + ACC_W'(quot);
            flt_q <= FLT_DONE;
          end
        end
        FLT_DONE: begin
          upd_q <= 1'b1;
          flt_q <= FLT_IDLE;
        end
        default: flt_q <= FLT_IDLE;
      endcase
    end
  end

  // saturate the filtered value into the limits
  assign filt = acc_q[ACC_W-1:FRAC_W];
  assign clamped = (filt > lim_hi) ? lim_hi : ((filt < lim_lo) ? lim_lo : filt);

  // hold modes; plain hold wins over max, max over min
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pv_q <= '0;
      hold_prev_q <= 3'h0;
      PV_OUT_VALID <= 1'b0;
      PV_BLINK <= 1'b0;
    end else begin
      hold_prev_q <= di_sync_q;
      PV_OUT_VALID <= upd_q;
      PV_BLINK <= |di_sync_q;
      if (di_sync_q[0]) begin
        pv_q <= pv_q;
      end else if (di_sync_q[1]) begin
        if (!hold_prev_q[1] || hold_prev_q[0]) begin
          pv_q <= clamped;
        end else if (upd_q && clamped > pv_q) begin
          pv_q <= clamped;
        end
      end else if (di_sync_q[2]) begin
        if (!hold_prev_q[2] || (|hold_prev_q[1:0])) begin
          pv_q <= clamped;
        end else if (upd_q && clamped < pv_q) begin
          pv_q <= clamped;
        end
      end else if (upd_q) begin
        pv_q <= clamped;
      end
    end
  end
  assign PV_OUT = pv_q;

  // correction readback shows -20.00 as -19.99
  assign corr_show = (lead_resistance_correction_q < CORR_SHOW_MIN) ? CORR_SHOW_MIN
                     : lead_resistance_correction_q;

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (PADDR)
      OFS_LAG: rd_d = {20'h0_0000, lag_time_setting_q};
      OFS_RATIO: rd_d = {18'h0_0000, ratio_q};
      OFS_BIAS: rd_d = {16'h0000, bias_q};
      OFS_CODE: rd_d = {28'h000_0000, special_function_code_q};
      OFS_TYPE: rd_d = {24'h00_0000, type_q};
      OFS_RANGE_LO: rd_d = {16'h0000, range_lo_q};
      OFS_RANGE_HI: rd_d = {16'h0000, range_hi_q};
      OFS_CORR: rd_d = {16'h0000, corr_show};
      OFS_STATUS: begin
        rd_d[ST_ALM_HI] = UPPER_LIMIT_ALARM;
        rd_d[ST_ALM_LO] = LOWER_LIMIT_ALARM;
        rd_d[ST_BLINK] = PV_BLINK;
        rd_d[ST_CAL_AVAIL] = cal_avail;
        rd_d[ST_CAL_SHOWN] = (cal_q == CAL_SHOWN);
        rd_d[ST_CAL_REJECT] = cal_reject_q;
      end
      OFS_PV: rd_d = 32'($signed(pv_q));
      OFS_DIFF: rd_d = (cal_q == CAL_SHOWN) ? {16'h0000, diff_q} : 32'h0000_0000;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // no wait state; read data and ready come from flops loaded in the setup cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      if (PSEL && !PENABLE) begin
        PRDATA <= rd_d;
      end
    end
  end
endmodule // pvf_top

/* test_pvf_top.sv */
`timescale 1ns/1ps
module test_pvf_top;
  import pvf_pkg::*;
  localparam int SC = 200;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] level, ab_diff, meas, pv_in, res_ab_diff, res_meas, res_corr;
  logic pv_in_valid, meas_req, res_meas_valid, res_corr_valid, di_hold, di_max, di_min;
  logic [EXT_W-1:0] pv_out;
  logic pv_out_valid, alm_hi, alm_lo, blink;
  int fails = 0;
  int num_checks = 0;

  // 25 MHz
  always #20 clk = ~clk;

  pvf_top #(.SAMPLE_CYC(SC)) i_dut (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PV_IN(pv_in),
    .PV_IN_VALID(pv_in_valid), .DI_HOLD(di_hold), .DI_MAX_HOLD(di_max), .DI_MIN_HOLD(di_min),
    .RES_AB_DIFF(res_ab_diff), .RES_MEAS(res_meas), .RES_MEAS_VALID(res_meas_valid),
    .PV_OUT(pv_out), .PV_OUT_VALID(pv_out_valid), .UPPER_LIMIT_ALARM(alm_hi),
    .LOWER_LIMIT_ALARM(alm_lo), .PV_BLINK(blink), .RES_CORR(res_corr), .RES_CORR_VALID(res_corr_valid)
  );
  pvf_front_model i_front (
    .clk(clk), .srst(srst), .level(level), .ab_diff(ab_diff), .meas(meas), .meas_req(meas_req),
    .pv_in(pv_in), .pv_in_valid(pv_in_valid), .res_ab_diff(res_ab_diff), .res_meas(res_meas),
    .res_meas_valid(res_meas_valid)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp);
  endtask

  // wait for the next delivered value
  task automatic upd();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pv_out_valid !== 1'b1 && n < 3 * SC);
    if (n >= 3 * SC) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  // two updates so the new level is surely latched
  task automatic step(input logic [15:0] lvl, input logic [31:0] exp, input logic [1:0] alm);
    level <= lvl;
    upd();
    upd();
    chk($signed(pv_out), exp);
    chk({alm_hi, alm_lo}, alm);
  endtask

  // two filter ticks, the shortened SC sample period the bench fixes
  task automatic settle();
    repeat (2 * SC + 60) @(posedge clk);
  endtask

  task automatic mchk(input logic [31:0] exp);
    int n;
    n = 0;
    meas_req <= 1'b1;
    @(posedge clk);
    meas_req <= 1'b0;
    while (res_corr_valid !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    // a missing strobe must not let a stale value pass
    chk({31'h0000_0000, res_corr_valid}, 32'h0000_0001);
    chk(res_corr, exp);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog, well past the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    level = 16'h0000;
    ab_diff = 16'h0123;
    meas = 16'h2710;
    meas_req = 1'b0;
    di_hold = 1'b0;
    di_max = 1'b0;
    di_min = 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(OFS_LAG, 32'h0000_0000);
    rdchk(OFS_CODE, 32'h0000_0000);
    rdchk(OFS_CORR, 32'h0000_0000);
    rdchk(OFS_RATIO, 32'h0000_03E8);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    wr(OFS_LAG, 32'h0000_04B1);
    rdchk(OFS_LAG, 32'h0000_0000);
    wr(OFS_LAG, 32'h0000_04B0);
    rdchk(OFS_LAG, 32'h0000_04B0);
    $display("test registers done");
    wr(OFS_LAG, 32'h0000_0000);
    wr(OFS_RATIO, 32'h0000_07D0);
    wr(OFS_BIAS, 32'h0000_000A);
    step(16'h01F4, 32'h0000_03F2, 2'h0);
    step(16'h0258, 32'h0000_044C, 2'h0);
    wr(OFS_RATIO, 32'h0000_03E8);
    wr(OFS_BIAS, 32'h0000_0000);
    step(16'h044C, 32'h0000_044C, 2'h0);
    step(16'h044D, 32'h0000_044C, 2'h2);
    step(16'hFF9B, 32'hFFFF_FF9C, 2'h1);
    wr(OFS_RANGE_LO, 32'h0000_0064);
    wr(OFS_RANGE_HI, 32'h0000_00C8);
    step(16'h00D3, 32'h0000_00D2, 2'h2);
    rdchk(OFS_STATUS, 32'h0000_0001, 32'h0000_0003);
    wr(OFS_RANGE_LO, 32'h0000_0000);
    wr(OFS_RANGE_HI, 32'h0000_03E8);
    step(16'h0000, 32'h0000_0000, 2'h0);
    wr(OFS_LAG, 32'h0000_0005);
    level <= 16'h0190;
    upd();
    chk($signed(pv_out), 32'h0000_00C8);
    upd();
    chk($signed(pv_out), 32'h0000_012C);
    upd();
    chk($signed(pv_out), 32'h0000_015E);
    rdchk(OFS_PV, 32'h0000_015E);
    wr(OFS_LAG, 32'h0000_0000);
    $display("test filter and limits done");
    step(16'h0064, 32'h0000_0064, 2'h0);
    di_hold <= 1'b1;
    level <= 16'h02BC;
    settle();
    chk($signed(pv_out), 32'h0000_0064);
    chk({31'h0000_0000, blink}, 32'h0000_0001);
    rdchk(OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    di_hold <= 1'b0;
    step(16'h0064, 32'h0000_0064, 2'h0);
    di_max <= 1'b1;
    repeat (10) @(posedge clk);
    level <= 16'h0032;
    settle();
    chk($signed(pv_out), 32'h0000_0064);
    level <= 16'h012C;
    settle();
    chk($signed(pv_out), 32'h0000_012C);
    di_max <= 1'b0;
    di_min <= 1'b1;
    repeat (10) @(posedge clk);
    level <= 16'h0190;
    settle();
    chk($signed(pv_out), 32'h0000_012C);
    level <= 16'h0078;
    settle();
    chk($signed(pv_out), 32'h0000_0078);
    di_min <= 1'b0;
    settle();
    chk({31'h0000_0000, blink}, 32'h0000_0000);
    $display("test hold modes done");
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_DIFF, 32'h0000_0000);
    wr(OFS_CODE, 32'h0000_0005);
    rdchk(OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_DIFF, 32'h0000_0123);
    rdchk(OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_CORR, 32'h0000_0123);
    wr(OFS_CORR, 32'h0000_0055);
    rdchk(OFS_CORR, 32'h0000_0123);
    mchk(32'h0000_25ED);
    wr(OFS_TYPE, 32'h0000_003F);
    mchk(32'h0000_25ED);
    wr(OFS_TYPE, 32'h0000_0001);
    mchk(32'h0000_2710);
    rdchk(OFS_STATUS, 32'h0000_0000, 32'h0000_0008);
    wr(OFS_TYPE, 32'h0000_0035);
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_DIFF, 32'h0000_0000);
    wr(OFS_TYPE, 32'h0000_0029);
    ab_diff <= 16'h07D0;
    wr(OFS_CAL_CMD, 32'h0000_0001);
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_CORR, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
    ab_diff <= 16'h07CF;
    wr(OFS_CAL_CMD, 32'h0000_0001);
    wr(OFS_CAL_CMD, 32'h0000_0001);
    rdchk(OFS_CORR, 32'h0000_07CF);
    $display("test calibration done");
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdchk(OFS_CODE, 32'h0000_0000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // test_pvf_top
